// File: rtl/tmr_opt_defines.svh
// register offset, field positions and reset value of the option register
`ifndef TMR_OPT_DEFINES_SVH
`define TMR_OPT_DEFINES_SVH
`define OPT_ADDR 12'h081
`define OPT_BYTE_ADDR 12'h204
`define OPT_RESET 8'hff
`define OPT_PU_DIS_BIT 7
`define OPT_EDGE_BIT 6
`define OPT_SRC_BIT 5
`define OPT_SE_BIT 4
`define OPT_PSA_BIT 3
`define OPT_RATE_HI 2
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// File: rtl/tmr_opt_pkg.sv
// types shared by the option register block
package tmr_opt_pkg;
  typedef struct packed {
    logic pullup_disable_n;
    logic ext_irq_edge_sel;
    logic timer_clk_src_sel;
    logic timer_src_edge_sel;
    logic prescaler_assign;
    logic [2:0] prescaler_rate;
  } opt_fields_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RESP = 2'b01
  } bus_state_t;
endpackage

// File: rtl/sync3.sv
// three-stage pin synchroniser with agreement-based change
module sync3 (
  input wire logic clk,
  input wire logic nrst,
  input wire logic din,
  output logic dout
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule // sync3

// File: rtl/timer_irq_pullup_config_reg.sv
// option register with AXI4-Lite access and its decoded control outputs
// How it works
// - 8-bit read/write register at data address 0x81.
// - bit 7 high turns all port B pull-ups off, else per latch.
// - bit 6 selects rising (1) or falling (0) external interrupt edge.
// - bit 5 selects external timer pin (1) or instruction clock (0).
// - bit 4 selects falling (1) or rising (0) external pin count edge.
// - bit 3 gives prescaler to watchdog; timer then counts 1:1.
`include "tmr_opt_defines.svh"
module timer_irq_pullup_config_reg
  import tmr_opt_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // axi4-lite write
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // pins
  input wire logic EXT_IRQ_PIN,
  input wire logic EXT_TIMER_CLK_PIN,
  input wire logic INSTR_CYCLE_CLK,
  input wire logic [7:0] PORT_B_LATCH,
  // to timer, prescaler and port logic
  output logic [7:0] PORT_B_PULLUP_EN,
  output logic EXT_IRQ_EVENT,
  output logic TIMER_TICK,
  output logic TIMER_PRESCALED,
  output logic WDT_PRESCALED,
  output logic [2:0] PRESCALER_RATE
);
  opt_fields_t opt;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic w_strb0;
  bus_state_t wstate;
  logic irq_s;
  logic irq_q;
  logic tck_s;
  logic tck_q;
  logic icc_q;

  function automatic logic hit(input logic [11:0] a);
    hit = (a == `OPT_BYTE_ADDR);
  endfunction

  // write channel: address and data captured in either order
  wire wr_go = aw_held && w_held && (wstate == ST_IDLE);
  wire wr_hit = hit(aw_addr);
  wire [7:0] next_opt = (wr_hit && w_strb0) ? w_data[7:0] : opt;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb0 <= 1'b0;
      wstate <= ST_IDLE;
      BVALID <= 1'b0;
      BRESP <= `RESP_OKAY;
      opt <= `OPT_RESET;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb0 <= WSTRB[0];
      end
      case (wstate)
        ST_IDLE: begin
          if (wr_go) begin
            opt <= next_opt;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            BVALID <= 1'b1;
            BRESP <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            wstate <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (BREADY) begin
            BVALID <= 1'b0;
            wstate <= ST_IDLE;
          end
        end
        default: wstate <= ST_IDLE;
      endcase
    end
  end

  // one item per channel until the response is taken
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
    end else begin
      AWREADY <= !aw_held && !(AWVALID && AWREADY) && (wstate == ST_IDLE);
      WREADY <= !w_held && !(WVALID && WREADY) && (wstate == ST_IDLE);
    end
  end

  // read channel
  wire rd_take = ARVALID && ARREADY;
  wire [31:0] rd_word = hit(ARADDR) ? {24'h000000, opt} : 32'h00000000;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= `RESP_OKAY;
    end else begin
      ARREADY <= !RVALID && !rd_take;
      if (rd_take) begin
        RVALID <= 1'b1;
        RDATA <= rd_word;
        RRESP <= hit(ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // pin synchronisers
  sync3 u_irq_sync (
    .clk(CLK),
    .nrst(NRST),
    .din(EXT_IRQ_PIN),
    .dout(irq_s)
  );
  sync3 u_tck_sync (
    .clk(CLK),
    .nrst(NRST),
    .din(EXT_TIMER_CLK_PIN),
    .dout(tck_s)
  );

  // edge decode; the edge select acts on the very next sampled change
  wire irq_edge = opt.ext_irq_edge_sel ? (irq_s && !irq_q)
                                       : (!irq_s && irq_q);
  wire pin_edge = opt.timer_src_edge_sel ? (!tck_s && tck_q)
                                         : (tck_s && !tck_q);
  wire icc_edge = INSTR_CYCLE_CLK && !icc_q;
  wire tick = opt.timer_clk_src_sel ? pin_edge : icc_edge;
  wire [7:0] next_pullup = opt.pullup_disable_n ? 8'h00
                                                : PORT_B_LATCH;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      irq_q <= 1'b0;
      tck_q <= 1'b0;
      icc_q <= 1'b0;
      EXT_IRQ_EVENT <= 1'b0;
      TIMER_TICK <= 1'b0;
      TIMER_PRESCALED <= 1'b0;
      WDT_PRESCALED <= 1'b0;
      PRESCALER_RATE <= 3'h0;
      PORT_B_PULLUP_EN <= 8'h00;
    end else begin
      irq_q <= irq_s;
      tck_q <= tck_s;
      icc_q <= INSTR_CYCLE_CLK;
      EXT_IRQ_EVENT <= irq_edge;
      TIMER_TICK <= tick;
      // timer bypasses the prescaler when it belongs to the watchdog
      TIMER_PRESCALED <= !opt.prescaler_assign;
      WDT_PRESCALED <= opt.prescaler_assign;
      PRESCALER_RATE <= opt.prescaler_rate;
      PORT_B_PULLUP_EN <= next_pullup;
    end
  end

  // NRST in an antecedent keeps the release edge out: the outputs
  // still show their reset values in the cycle after it

  // pull-up enables
  a_pullup_off: assert property (@(posedge CLK)
    disable iff (!NRST)
    NRST && opt.pullup_disable_n |=> PORT_B_PULLUP_EN == 8'h00)
    else $error("pull-ups on while disabled");
  a_pullup_latch: assert property (@(posedge CLK)
    disable iff (!NRST)
    NRST && !opt.pullup_disable_n
      |=> PORT_B_PULLUP_EN == $past(PORT_B_LATCH))
    else $error("pull-ups do not follow latch");

  // external interrupt edge
  a_irq_rise: assert property (@(posedge CLK)
    disable iff (!NRST)
    NRST && opt.ext_irq_edge_sel && irq_s && !irq_q |=> EXT_IRQ_EVENT)
    else $error("rising interrupt edge missed");
  a_irq_fall: assert property (@(posedge CLK)
    disable iff (!NRST)
    NRST && !opt.ext_irq_edge_sel && !irq_s && irq_q |=> EXT_IRQ_EVENT)
    else $error("falling interrupt edge missed");
  a_irq_no_fall: assert property (@(posedge CLK)
    disable iff (!NRST)
    NRST && opt.ext_irq_edge_sel && !irq_s && irq_q |=> !EXT_IRQ_EVENT)
    else $error("falling edge taken while rising selected");
  a_irq_no_rise: assert property (@(posedge CLK)
    disable iff (!NRST)
    NRST && !opt.ext_irq_edge_sel && irq_s && !irq_q |=> !EXT_IRQ_EVENT)
    else $error("rising edge taken while falling selected");
  a_irq_quiet: assert property (@(posedge CLK)
    disable iff (!NRST)
    NRST && (irq_s == irq_q) |=> !EXT_IRQ_EVENT)
    else $error("interrupt event without pin edge");
  a_irq_pulse: assert property (@(posedge CLK)
    disable iff (!NRST)
    EXT_IRQ_EVENT |=> !EXT_IRQ_EVENT)
    else $error("interrupt event longer than one cycle");

  // timer tick source and edge
  a_src_internal: assert property (@(posedge CLK)
    disable iff (!NRST)
    NRST && !opt.timer_clk_src_sel && INSTR_CYCLE_CLK && !icc_q
      |=> TIMER_TICK)
    else $error("instruction clock tick missed");
  a_src_int_quiet: assert property (@(posedge CLK)
    disable iff (!NRST)
    NRST && !opt.timer_clk_src_sel && !(INSTR_CYCLE_CLK && !icc_q)
      |=> !TIMER_TICK)
    else $error("tick without instruction clock edge");
  a_src_pin_quiet: assert property (@(posedge CLK)
    disable iff (!NRST)
    NRST && opt.timer_clk_src_sel && (tck_s == tck_q) |=> !TIMER_TICK)
    else $error("tick without timer pin edge");
  a_pin_rise: assert property (@(posedge CLK)
    disable iff (!NRST)
    NRST && opt.timer_clk_src_sel && !opt.timer_src_edge_sel
      && tck_s && !tck_q |=> TIMER_TICK)
    else $error("rising pin edge not counted");
  a_pin_fall: assert property (@(posedge CLK)
    disable iff (!NRST)
    NRST && opt.timer_clk_src_sel && opt.timer_src_edge_sel
      && !tck_s && tck_q |=> TIMER_TICK)
    else $error("falling pin edge not counted");
  a_pin_wrong_edge: assert property (@(posedge CLK)
    disable iff (!NRST)
    NRST && opt.timer_clk_src_sel
      && (opt.timer_src_edge_sel ? (tck_s && !tck_q) : (!tck_s && tck_q))
      |=> !TIMER_TICK)
    else $error("pin edge of the wrong sense counted");

  // prescaler assignment and rate
  a_psa_wdt: assert property (@(posedge CLK)
    disable iff (!NRST)
    NRST && opt.prescaler_assign |=> WDT_PRESCALED && !TIMER_PRESCALED)
    else $error("prescaler not with watchdog");
  a_psa_timer: assert property (@(posedge CLK)
    disable iff (!NRST)
    NRST && !opt.prescaler_assign |=> !WDT_PRESCALED && TIMER_PRESCALED)
    else $error("prescaler not with timer");
  a_rate_out: assert property (@(posedge CLK)
    disable iff (!NRST)
    NRST |=> PRESCALER_RATE == $past(opt.prescaler_rate))
    else $error("rate not forwarded");

  // register writes; lane 0 alone carries the register
  a_write_reg: assert property (@(posedge CLK)
    disable iff (!NRST)
    wr_go && wr_hit && w_strb0 |=> opt == $past(w_data[7:0]))
    else $error("register write lost");
  a_write_keep: assert property (@(posedge CLK)
    disable iff (!NRST)
    NRST && !(wr_go && wr_hit && w_strb0) |=> opt == $past(opt))
    else $error("register changed without a write");
  a_write_ok: assert property (@(posedge CLK)
    disable iff (!NRST)
    wr_go && aw_addr == `OPT_BYTE_ADDR
      |=> BVALID && BRESP == `RESP_OKAY)
    else $error("mapped write not answered okay");
  a_write_err: assert property (@(posedge CLK)
    disable iff (!NRST)
    wr_go && aw_addr != `OPT_BYTE_ADDR
      |=> BVALID && BRESP == `RESP_SLVERR)
    else $error("unmapped write not answered with error");
  a_b_hold: assert property (@(posedge CLK)
    disable iff (!NRST)
    BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped before taken");
  a_b_busy: assert property (@(posedge CLK)
    disable iff (!NRST)
    BVALID |-> !AWREADY && !WREADY)
    else $error("write accepted while response pending");

  // register reads
  a_read_ok: assert property (@(posedge CLK)
    disable iff (!NRST)
    ARVALID && ARREADY && ARADDR == `OPT_BYTE_ADDR
      |=> RVALID && RRESP == `RESP_OKAY
      && RDATA == {24'h000000, $past(opt)})
    else $error("read data or response wrong");
  a_read_err: assert property (@(posedge CLK)
    disable iff (!NRST)
    ARVALID && ARREADY && ARADDR != `OPT_BYTE_ADDR
      |=> RVALID && RRESP == `RESP_SLVERR
      && RDATA == 32'h00000000)
    else $error("unmapped read not answered with error");
  a_r_hold: assert property (@(posedge CLK)
    disable iff (!NRST)
    RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
    else $error("read answer dropped before taken");
  a_r_busy: assert property (@(posedge CLK)
    disable iff (!NRST)
    RVALID |-> !ARREADY)
    else $error("read accepted while answer pending");
endmodule // timer_irq_pullup_config_reg

// File: testbench/timer_irq_pullup_config_reg_tb.sv
// self-checking bench for the option register block
`include "tmr_opt_defines.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
  $display("Error at %0t got %h exp %h", $time, (a), (e)); end end
module timer_irq_pullup_config_reg_tb import tmr_opt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rdata, r;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  // pins[0] irq pin, pins[1] timer clock pin, pins[2] instruction clock
  logic [2:0] pins = '0, rate;
  logic [7:0] latch = '0, pu_en, cfg;
  logic irq_ev, tick, tmr_pre, wdt_pre;
  logic [33:0] exp_q[$], exp_r;
  logic [1:0] exp_b[$], exp_br;
  int err_count = 0, n_tests = 0, seed = 27430, irq_cnt = 0, tick_cnt = 0;
  int i0, t0;
  always #5 clk = ~clk;
  timer_irq_pullup_config_reg i_dut (.CLK(clk), .NRST(nrst),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
    .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .EXT_IRQ_PIN(pins[0]), .EXT_TIMER_CLK_PIN(pins[1]),
    .INSTR_CYCLE_CLK(pins[2]), .PORT_B_LATCH(latch),
    .PORT_B_PULLUP_EN(pu_en), .EXT_IRQ_EVENT(irq_ev), .TIMER_TICK(tick),
    .TIMER_PRESCALED(tmr_pre), .WDT_PRESCALED(wdt_pre),
    .PRESCALER_RATE(rate));
  always @(posedge clk) begin
    if (irq_ev === 1'b1) irq_cnt <= irq_cnt + 1;
    if (tick === 1'b1) tick_cnt <= tick_cnt + 1;
    if (rvalid === 1'b1 && rready) begin
      exp_r = exp_q.pop_front();
      `CHK({rresp, rdata}, exp_r)
    end
    if (bvalid === 1'b1 && bready) begin
      exp_br = exp_b.pop_front();
      `CHK(bresp, exp_br)
    end
  end
  task automatic complete_run();
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // upper data bits are set to show they are ignored
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] e);
    awaddr <= a;
    wdata <= {24'hffffff, d};
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    exp_b.push_back(e);
    forever begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid === 1'b1) break;
    end
    bready <= 0;
    if (a == `OPT_BYTE_ADDR && s[0]) cfg = d;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    exp_q.push_back(e);
    forever begin
      @(posedge clk);
      if (arready) arvalid <= 0;
      if (rvalid === 1'b1) break;
    end
    rready <= 0;
    @(posedge clk);
  endtask
  task automatic chk_out();
    repeat (3) @(posedge clk);
    `CHK(pu_en, cfg[7] ? 8'h00 : latch)
    `CHK({tmr_pre, wdt_pre}, {~cfg[3], cfg[3]})
    `CHK(rate, cfg[2:0])
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run();
  end
  initial begin
    cfg = `OPT_RESET;
    repeat (8) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    chk_out();
    rd(`OPT_BYTE_ADDR, {`RESP_OKAY, 24'h0, cfg});
    rd(12'h000, {`RESP_SLVERR, 32'h0});
    wr(12'h000, 8'h00, 4'hf, `RESP_SLVERR);
    // random strobes also exercise the no-change path of lane 0
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      latch <= r[23:16];
      wr(`OPT_BYTE_ADDR, r[7:0], r[11:8], `RESP_OKAY);
      rd(`OPT_BYTE_ADDR, {`RESP_OKAY, 24'h0, cfg});
      chk_out();
    end
    for (int k = 0; k < 2; k++) begin
      wr(`OPT_BYTE_ADDR, {1'b0, k[0], 1'b1, k[0], 4'h0}, 4'h1, `RESP_OKAY);
      i0 = irq_cnt;
      t0 = tick_cnt;
      pins <= 3'b111;
      repeat (8) @(posedge clk);
      `CHK(irq_cnt - i0, k)
      `CHK(tick_cnt - t0, 1 - k)
      pins <= 3'b000;
      repeat (8) @(posedge clk);
      `CHK(irq_cnt - i0, 1)
      `CHK(tick_cnt - t0, 1)
    end
    wr(`OPT_BYTE_ADDR, 8'h00, 4'h1, `RESP_OKAY);
    t0 = tick_cnt;
    pins <= 3'b010;
    repeat (8) @(posedge clk);
    pins <= 3'b110;
    repeat (8) @(posedge clk);
    `CHK(tick_cnt - t0, 1)
    // a reset in mid-run must bring back the reset value
    nrst <= 0;
    repeat (2) @(posedge clk);
    nrst <= 1;
    cfg = `OPT_RESET;
    chk_out();
    rd(`OPT_BYTE_ADDR, {`RESP_OKAY, 24'h0, cfg});
    complete_run();
  end
endmodule // timer_irq_pullup_config_reg_tb
